// ### rtl/i2csf_addr_check.v
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// address byte decode: extension code and own-address compare
module i2csf_addr_check (
  // received address byte and own slave address
  input  wire [7:0] addr_byte_in,
  input  wire [7:0] own_addr_in,
  // decode results
  output wire       is_ext_out,
  output wire       is_match_out
);
  // upper nibble all zeros or all ones
  assign is_ext_out   = (addr_byte_in[7:4] == 4'h0) || (addr_byte_in[7:4] == 4'hf);
  // compare the seven address bits, direction bit ignored
  assign is_match_out = (addr_byte_in[7:1] == own_addr_in[7:1]);
endmodule // i2csf_addr_check
`default_nettype wire

// ### rtl/i2csf_regs.vh
`ifndef I2CSF_REGS_VH
`define I2CSF_REGS_VH
// ==========================================================================
// status register address and layout
`define I2CSF_STATUS_ADDR   16'hffa9
`define I2CSF_STATUS_RESET  8'h00
`define I2CSF_BIT_MASTER    7
`define I2CSF_BIT_ARBLOST   6
`define I2CSF_BIT_EXTCODE   5
`define I2CSF_BIT_ADDRMATCH 4
`define I2CSF_BIT_TXDIR     3
`define I2CSF_BIT_ACK       2
`define I2CSF_BIT_START     1
`define I2CSF_BIT_STOP      0
// ==========================================================================
// control register bits that feed the flags
`define I2CSF_CTRL_EXIT     6
`define I2CSF_CTRL_ENABLE   7
`endif

// ### rtl/i2csf_status.v
// What this block does
// - reset clears whole status register to zero
// - status readable as byte or single bit
// - read-only status at fixed address, fixed layout
// - master flag set on generated start
// - master cleared: stop, arb loss, exit, disable
// - arbitration loss sets flag, clears master
// - arb-lost cleared after read, disable, reset
// - bit instruction elsewhere clears arb-lost
// - extension flag set on eighth clock
// - extension cleared: start, stop, exit, disable
// - address match set on eighth clock
// - match cleared: start, stop, exit, disable
// - exit control is control bit six
// - enable is control bit seven, falling clears
// - direction flag: 1 transmit drives, 0 releases
`timescale 1ns/1ps
`default_nettype none
`include "i2csf_regs.vh"
module i2csf_status (
  // clock and reset
  input  wire       clk_in,
  input  wire       resetn_in,
  // cpu read port
  input  wire [15:0] cpu_addr_in,
  input  wire       cpu_rd_in,
  input  wire       cpu_bit_in,
  input  wire [2:0] cpu_bitsel_in,
  input  wire       cpu_bitop_in,
  // control register and own address
  input  wire [7:0] ctrl_reg_in,
  input  wire       ctrl_wr_in,
  input  wire [7:0] own_slave_addr_reg_in,
  // bus engine events
  input  wire       start_gen_in,
  input  wire       start_det_in,
  input  wire       stop_det_in,
  input  wire       arb_loss_in,
  input  wire       clk8_rise_in,
  input  wire [7:0] addr_byte_in,
  input  wire       dir_tx_set_in,
  input  wire       dir_tx_clr_in,
  input  wire       ack_seen_in,
  input  wire       start_seen_in,
  input  wire       stop_seen_in,
  // read data and data line drive
  output reg  [7:0] rd_data_out,
  output reg        rd_valid_out,
  output reg        sda_oe_out
);
  // ========================================================================
  // flag registers
  // sticky status flags
  reg        master_active_flag_r;
  reg        arb_lost_flag_r;
  reg        ext_code_flag_r;
  reg        addr_match_flag_r;
  reg        transmit_dir_flag_r;
  // engine-supplied seen flags
  reg        ack_seen_flag_r;
  reg        start_seen_flag_r;
  reg        stop_seen_flag_r;
  // enable history for the falling-edge detect
  reg        enable_prev_r;
  // next values of the sticky flags
  wire       master_active_flag_nxt;
  wire       arb_lost_flag_nxt;
  wire       ext_code_flag_nxt;
  wire       addr_match_flag_nxt;
  wire       transmit_dir_flag_nxt;
  // address decode results
  wire       is_ext;
  wire       is_match;
  // assembled status byte
  wire [7:0] bus_status_reg;
  // decoded cpu and control events
  wire       sel;
  wire       exit_req;
  wire       en_fall;
  wire       status_rd;
  wire       other_bitop;
  // set and clear terms per flag
  wire       session_clr;
  wire       master_set;
  wire       master_clr;
  wire       arb_clr;
  wire       ext_set;
  wire       match_set;
  wire       code_clr;
  wire       dir_clr;

  // ========================================================================
  // next value of a sticky flag; a set in the same cycle beats a clear
  function flag_next;
    input cur_val;
    input set_val;
    input clr_val;
    begin
      if (set_val) begin
        flag_next = 1'b1;
      end else if (clr_val) begin
        flag_next = 1'b0;
      end else begin
        flag_next = cur_val;
      end
    end
  endfunction

  // address byte decode
  i2csf_addr_check u_chk (
    .addr_byte_in (addr_byte_in),
    .own_addr_in  (own_slave_addr_reg_in),
    .is_ext_out   (is_ext),
    .is_match_out (is_match)
  );

  // ========================================================================
  // decoded cpu and control events
  assign sel         = (cpu_addr_in == `I2CSF_STATUS_ADDR);
  assign exit_req    = ctrl_wr_in && ctrl_reg_in[`I2CSF_CTRL_EXIT];
  assign en_fall     = enable_prev_r && !ctrl_reg_in[`I2CSF_CTRL_ENABLE];
  assign status_rd   = cpu_rd_in && sel;
  assign other_bitop = cpu_bitop_in && !sel;

  // events that end a session for every sticky flag except arbitration lost
  assign session_clr = stop_det_in || exit_req || en_fall;
  // master: set by a generated start unless arbitration is lost that cycle
  assign master_set  = start_gen_in && !arb_loss_in;
  assign master_clr  = session_clr || arb_loss_in;
  // arbitration: any status read, a bit instruction elsewhere, or disable
  assign arb_clr     = status_rd || other_bitop || en_fall;
  // extension code and address match share the eighth-clock strobe
  assign ext_set     = clk8_rise_in && is_ext;
  assign match_set   = clk8_rise_in && is_match;
  assign code_clr    = start_det_in || session_clr;
  // direction: engine clear pulse or end of session
  assign dir_clr     = dir_tx_clr_in || session_clr;

  // status byte in register order, master flag in bit 7
  assign bus_status_reg = {master_active_flag_r, arb_lost_flag_r, ext_code_flag_r,
                           addr_match_flag_r, transmit_dir_flag_r, ack_seen_flag_r,
                           start_seen_flag_r, stop_seen_flag_r};

  // ========================================================================
  // next values of the sticky flags
  assign master_active_flag_nxt = flag_next(master_active_flag_r, master_set, master_clr);
  assign arb_lost_flag_nxt      = flag_next(arb_lost_flag_r, arb_loss_in, arb_clr);
  assign ext_code_flag_nxt      = flag_next(ext_code_flag_r, ext_set, code_clr);
  assign addr_match_flag_nxt    = flag_next(addr_match_flag_r, match_set, code_clr);
  assign transmit_dir_flag_nxt  = flag_next(transmit_dir_flag_r, dir_tx_set_in, dir_clr);

  // enable history for the falling-edge detect
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      enable_prev_r <= 1'b0;
    end else begin
      enable_prev_r <= ctrl_reg_in[`I2CSF_CTRL_ENABLE];
    end
  end

  // ========================================================================
  // session flags: master, extension, match, direction
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      master_active_flag_r <= 1'b0;
      ext_code_flag_r      <= 1'b0;
      addr_match_flag_r    <= 1'b0;
      transmit_dir_flag_r  <= 1'b0;
    end else begin
      master_active_flag_r <= master_active_flag_nxt;
      ext_code_flag_r      <= ext_code_flag_nxt;
      addr_match_flag_r    <= addr_match_flag_nxt;
      transmit_dir_flag_r  <= transmit_dir_flag_nxt;
    end
  end

  // arbitration flag; the clearing read has already latched it as set
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      arb_lost_flag_r <= 1'b0;
    end else begin
      arb_lost_flag_r <= arb_lost_flag_nxt;
    end
  end

  // engine-supplied seen levels, mirrored one cycle late
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ack_seen_flag_r   <= 1'b0;
      start_seen_flag_r <= 1'b0;
      stop_seen_flag_r  <= 1'b0;
    end else begin
      ack_seen_flag_r   <= ack_seen_in;
      start_seen_flag_r <= start_seen_in;
      stop_seen_flag_r  <= stop_seen_in;
    end
  end

  // ========================================================================
  // read port: whole byte, or the selected bit in bit 0
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_data_out  <= `I2CSF_STATUS_RESET;
      rd_valid_out <= 1'b0;
    end else begin
      rd_valid_out <= status_rd;
      if (status_rd) begin
        if (cpu_bit_in) begin
          rd_data_out <= {7'h00, bus_status_reg[cpu_bitsel_in]};
        end else begin
          rd_data_out <= bus_status_reg;
        end
      end
    end
  end

  // data line drive follows the direction flag; low releases the line
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sda_oe_out <= 1'b0;
    end else begin
      sda_oe_out <= transmit_dir_flag_r;
    end
  end
endmodule // i2csf_status
`default_nettype wire

// ### verif/i2csf_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// bus engine model: one-cycle event pulses and seen levels
module i2csf_engine_model (
  // requested events and levels
  input  wire logic [6:0] ev_in,
  input  wire logic [2:0] lv_in,
  // start_gen, start_det, stop_det, arb, clk8, tx_set, tx_clr, ack, start, stop
  output logic [9:0]      ev_out
);
  // pulses last exactly the cycle the bench asks for
  assign ev_out = {ev_in, lv_in};
endmodule // i2csf_engine_model
`default_nettype wire

// ### verif/i2csf_status_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// status flag checker
module i2csf_props (
  // clock and reset
  input wire logic        clk_in,
  input wire logic        resetn_in,
  // cpu read request
  input wire logic [15:0] cpu_addr_in,
  input wire logic        cpu_rd_in,
  input wire logic        cpu_bit_in,
  // own address and engine events
  input wire logic [7:0]  own_slave_addr_reg_in,
  input wire logic [7:0]  addr_byte_in,
  input wire logic        start_gen_in,
  input wire logic        stop_det_in,
  input wire logic        arb_loss_in,
  input wire logic        clk8_rise_in,
  input wire logic        dir_tx_set_in,
  // design outputs
  input wire logic [7:0]  rd_data_out,
  input wire logic        rd_valid_out,
  input wire logic        sda_oe_out
);
  // taken status read, whole byte
  wire logic rd_ok = cpu_rd_in && cpu_addr_in == 16'hffa9;
  wire logic rb = rd_ok && !cpu_bit_in;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  AST_RST:
    assert property ($rose(resetn_in) |-> {sda_oe_out, rd_valid_out, rd_data_out} == 10'h000)
    else $error("outputs not clear after reset");
  AST_ANS:
    assert property (rd_ok |=> rd_valid_out) else $error("status read not answered");
  AST_REF:
    assert property (!rd_ok |=> !rd_valid_out) else $error("answer without status read");
  AST_MST:
    assert property (start_gen_in && !arb_loss_in ##1 rb |=> rd_data_out[7])
    else $error("master flag not set by start");
  AST_ARB:
    assert property (arb_loss_in ##1 rb |=> rd_data_out[7:6] == 2'b01)
    else $error("arbitration loss flags wrong");
  AST_ARBCLR:
    assert property ((rb && !arb_loss_in) [*2] |=> !rd_data_out[6])
    else $error("arbitration flag survives read");
  AST_EXT:
    assert property (clk8_rise_in && addr_byte_in[7:4] inside {4'h0, 4'hf} ##1 rb
      |=> rd_data_out[5]) else $error("extension flag not set");
  AST_MATCH:
    assert property (clk8_rise_in && addr_byte_in[7:1] == own_slave_addr_reg_in[7:1] ##1 rb
      |=> rd_data_out[4]) else $error("match flag not set");
  AST_STOP:
    assert property (stop_det_in && !start_gen_in && !clk8_rise_in ##1 rb
      |=> rd_data_out[7] == 1'b0 && rd_data_out[5:4] == 2'b00) else $error("stop left flags");
  AST_DIR:
    assert property (dir_tx_set_in |-> ##[1:2] sda_oe_out) else $error("data line not driven");
endmodule // i2csf_props
bind i2csf_status i2csf_props u_props (.cpu_addr_in, .addr_byte_in, .own_slave_addr_reg_in,
  .rd_data_out, .clk_in, .resetn_in, .cpu_rd_in, .cpu_bit_in, .start_gen_in, .stop_det_in,
  .arb_loss_in, .clk8_rise_in, .dir_tx_set_in, .rd_valid_out, .sda_oe_out);
`default_nettype wire

// ### verif/i2csf_status_test.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// status flag testbench
module i2csf_status_test;
  localparam logic [15:0] SA = 16'hffa9;
  logic clk = 1'b0, rstn = 1'b0, rd = 1'b0, bt = 1'b0, bop = 1'b0, wr = 1'b0;
  logic [15:0] adr = 16'h0000;
  logic [7:0]  ctl = 8'h80, own = 8'hf4, ab = 8'h00, dat;
  logic [6:0]  ev = 7'h00;
  logic [2:0]  sel = 3'h0, lv = 3'h0;
  logic        vld, oe;
  wire logic [9:0] g;
  int num_errors = 0, n_checks = 0, cycles = 0;
  i2csf_engine_model ENG (.ev_in(ev), .lv_in(lv), .ev_out(g));
  i2csf_status DUT (.clk_in(clk), .resetn_in(rstn), .cpu_addr_in(adr), .cpu_rd_in(rd),
    .cpu_bit_in(bt), .cpu_bitsel_in(sel), .cpu_bitop_in(bop), .ctrl_reg_in(ctl),
    .ctrl_wr_in(wr), .own_slave_addr_reg_in(own), .start_gen_in(g[9]), .start_det_in(g[8]),
    .stop_det_in(g[7]), .arb_loss_in(g[6]), .clk8_rise_in(g[5]), .addr_byte_in(ab),
    .dir_tx_set_in(g[4]), .dir_tx_clr_in(g[3]), .ack_seen_in(g[2]), .start_seen_in(g[1]),
    .stop_seen_in(g[0]), .rd_data_out(dat), .rd_valid_out(vld), .sda_oe_out(oe));
  // clock and hang guard
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      num_errors++;
      test_done;
    end
  end
  task test_done;
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [9:0] got, input logic [9:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one cycle: {rd,bit,sel}, {wr,bitop,events}; read result {oe,valid,data}
  task automatic cyc(input logic [15:0] a, input logic [4:0] r, input logic [8:0] e,
                     input logic [9:0] x);
    adr <= a;
    {rd, bt, sel} <= r;
    {wr, bop, ev} <= e;
    @(posedge clk);
    if (r[4]) fork
      #1 chk({oe, vld, dat}, x);
    join_none
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    cyc(SA, 5'h10, 9'h000, 10'h100);
    $display("test reset done");
    cyc(0, 0, 9'h040, 0);
    cyc(SA, 5'h10, 0, 10'h180);
    cyc(16'hffa8, 5'h10, 0, 10'h080);
    cyc(0, 0, 9'h008, 0);
    cyc(SA, 5'h10, 0, 10'h140);
    cyc(SA, 5'h10, 0, 10'h100);
    cyc(0, 0, 9'h008, 0);
    cyc(SA, 5'h1e, 0, 10'h101);
    cyc(0, 0, 9'h008, 0);
    cyc(16'hff20, 0, 9'h080, 0);
    cyc(SA, 5'h10, 0, 10'h100);
    cyc(0, 0, 9'h008, 0);
    ctl <= 8'h00;
    cyc(0, 0, 0, 0);
    ctl <= 8'h80;
    cyc(SA, 5'h10, 0, 10'h100);
    $display("test arbitration done");
    ab <= 8'h05;
    cyc(0, 0, 9'h004, 0);
    cyc(SA, 5'h10, 0, 10'h120);
    cyc(0, 0, 9'h020, 0);
    cyc(SA, 5'h10, 0, 10'h100);
    ab <= 8'hf5;
    cyc(0, 0, 9'h044, 0);
    cyc(SA, 5'h10, 0, 10'h1b0);
    ctl <= 8'hc0;
    cyc(0, 0, 9'h100, 0);
    ctl <= 8'h80;
    cyc(SA, 5'h10, 0, 10'h100);
    cyc(0, 0, 9'h044, 0);
    cyc(SA, 5'h10, 0, 10'h1b0);
    cyc(0, 0, 9'h010, 0);
    cyc(SA, 5'h10, 0, 10'h100);
    cyc(0, 0, 9'h044, 0);
    ctl <= 8'h00;
    cyc(SA, 5'h10, 0, 10'h1b0);
    ctl <= 8'h80;
    cyc(SA, 5'h10, 0, 10'h100);
    $display("test address done");
    cyc(0, 0, 9'h002, 0);
    cyc(SA, 5'h10, 0, 10'h308);
    cyc(0, 0, 9'h001, 0);
    cyc(SA, 5'h10, 0, 10'h100);
    lv <= 3'h5;
    cyc(0, 0, 0, 0);
    cyc(0, 0, 0, 0);
    cyc(SA, 5'h10, 0, 10'h105);
    lv <= 3'h2;
    cyc(0, 0, 0, 0);
    cyc(SA, 5'h10, 0, 10'h102);
    $display("test direction done");
    cyc(0, 0, 0, 0);
    #2 test_done;
  end
endmodule // i2csf_status_test
`default_nettype wire
